// ### logic/ccs_clock_control.v
// Purpose: fuse decode, wake and reset start-up timing, clock domain gating
// Assumes: sourceTick and watchdogTick are oscillator levels from outside clk
// Notes: clock enables are levels for the gating cells of each domain
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`include "ccs_regs.vh"

// What this block does
// - decode four source fuse bits into crystal, low crystal, ext RC, int RC, ext clock
// - fuse bit one means unprogrammed, zero means programmed
// - after power-down or power-save wake, hold core until source cycles counted
// - after reset add none, 4,096 or 65,536 watchdog cycles as the fuses select
// - fuses reset to source 0001 and start-up 10
// - crystal range from upper source bits, zero outside crystal mode
// - amplifier fuse programmed gives full swing in crystal mode, else reduced swing
// - crystal, variant bit clear: 258+4K, 258+64K, 1K, 1K+4K
// - crystal, variant bit set: 1K+64K, 16K, 16K+4K, 16K+64K
// - async timer clock only while running on the internal oscillator
// - core clock halted in sleep stops core operation
// - peripheral clock gated, async interrupt and address detection stay alive
// - program memory clock runs with the core clock
// - converter clock has its own enable, may run while core is halted
module ccs_clock_control #(
   parameter STARTUP_LONG = 17'h04000,
   parameter WATCHDOG_LONG = 17'h10000
) (
   input wire clk,
   input wire rst,
   input wire wbCycI,
   input wire wbStbI,
   input wire wbWeI,
   input wire [7:0] wbAdrI,
   input wire [3:0] wbSelI,
   input wire [31:0] wbDatI,
   output reg [31:0] wbDatO,
   output reg wbAckO,
   input wire sourceTick,
   input wire watchdogTick,
   input wire wakeEvent,
   output reg coreClockEn,
   output reg peripheralClockEn,
   output reg programMemoryClockEn,
   output reg asyncTimerClockEn,
   output reg converterClockEn,
   output reg asyncDetectEn,
   output reg amplifierFullSwing,
   output reg [4:0] sourceKind,
   output reg [2:0] crystalRange,
   output reg cpuHold
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam [4:0] ST_RUN = 5'h01;
   localparam [4:0] ST_SLEEP = 5'h02;
   localparam [4:0] ST_OSC = 5'h04;
   localparam [4:0] ST_WDOG = 5'h08;
   localparam [4:0] ST_LOAD = 5'h10;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [3:0] clockSourceFuses;
   reg [1:0] startupTimeFuses;
   reg amplifierOptionFuse;
   reg [1:0] sleepMode;
   reg asyncEnable;
   reg converterEnable;
   reg [4:0] state;
   reg [16:0] count;
   reg [16:0] wdogTarget;
   reg fromReset;
   reg sleepRequest;
   reg [2:0] srcSync;
   reg [2:0] wdSync;
   reg [2:0] wakeSync;
   reg srcLevel;
   reg wdLevel;
   reg wakeLevel;
   reg [16:0] next_oscTarget;
   reg [16:0] next_wdTarget;
   reg [4:0] next_kind;

   wire isCrystal = clockSourceFuses >= `CCS_SRC_XTAL_MIN;
   wire isInternal = (clockSourceFuses >= `CCS_SRC_IRC_MIN) &&
      (clockSourceFuses < `CCS_SRC_XRC_MIN);
   wire startupVariantFuse = clockSourceFuses[0];
   wire busReq = wbCycI && wbStbI && !wbAckO;
   wire busWrite = busReq && wbWeI && wbSelI[0];
   // a change counts only when the second and third stages agree
   wire srcEdge = (srcSync[2] == srcSync[1]) && srcSync[1] && !srcLevel;
   wire wdEdge = (wdSync[2] == wdSync[1]) && wdSync[1] && !wdLevel;
   wire wakeRise = (wakeSync[2] == wakeSync[1]) && wakeSync[1] && !wakeLevel;
   wire deepSleep = (sleepMode == `CCS_MODE_PDOWN) || (sleepMode == `CCS_MODE_PSAVE);

   // ----------------------------------------
   // fuse decode
   // ----------------------------------------
   always @* begin
      next_kind = 5'h00;
      if (isCrystal) begin
         next_kind = 5'h01;
      end else if (clockSourceFuses == `CCS_SRC_LFXTAL) begin
         next_kind = 5'h02;
      end else if (clockSourceFuses >= `CCS_SRC_XRC_MIN) begin
         next_kind = 5'h04;
      end else if (clockSourceFuses == `CCS_SRC_EXT) begin
         next_kind = 5'h10;
      end else begin
         next_kind = 5'h08;
      end
      next_oscTarget = `CCS_CK_6;
      next_wdTarget = `CCS_WD_NONE;
      if (isCrystal) begin
         case ({startupVariantFuse, startupTimeFuses})
            3'h0: begin
               next_oscTarget = `CCS_CK_258;
               next_wdTarget = `CCS_WD_4K;
            end
            3'h1: begin
               next_oscTarget = `CCS_CK_258;
               next_wdTarget = WATCHDOG_LONG;
            end
            3'h2: begin
               next_oscTarget = `CCS_CK_1K;
            end
            3'h3: begin
               next_oscTarget = `CCS_CK_1K;
               next_wdTarget = `CCS_WD_4K;
            end
            3'h4: begin
               next_oscTarget = `CCS_CK_1K;
               next_wdTarget = WATCHDOG_LONG;
            end
            3'h5: begin
               next_oscTarget = STARTUP_LONG;
            end
            3'h6: begin
               next_oscTarget = STARTUP_LONG;
               next_wdTarget = `CCS_WD_4K;
            end
            default: begin
               next_oscTarget = STARTUP_LONG;
               next_wdTarget = WATCHDOG_LONG;
            end
         endcase
      end else begin
         // other sources: short count, delay by start-up fuses alone
         case (startupTimeFuses)
            2'h0: next_wdTarget = `CCS_WD_NONE;
            2'h2: next_wdTarget = WATCHDOG_LONG;
            default: next_wdTarget = `CCS_WD_4K;
         endcase
      end
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         srcSync <= 3'h0;
         wdSync <= 3'h0;
         wakeSync <= 3'h0;
         srcLevel <= 1'b0;
         wdLevel <= 1'b0;
         wakeLevel <= 1'b0;
      end else begin
         srcSync <= {srcSync[1:0], sourceTick};
         wdSync <= {wdSync[1:0], watchdogTick};
         wakeSync <= {wakeSync[1:0], wakeEvent};
         if (srcSync[2] == srcSync[1]) srcLevel <= srcSync[2];
         if (wdSync[2] == wdSync[1]) wdLevel <= wdSync[2];
         if (wakeSync[2] == wakeSync[1]) wakeLevel <= wakeSync[2];
      end
   end

   // ----------------------------------------
   // wishbone slave and fuse/control registers
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         wbAckO <= 1'b0;
         wbDatO <= `CCS_ZERO32;
         clockSourceFuses <= `CCS_SRC_RESET;
         startupTimeFuses <= `CCS_STARTUP_RESET;
         amplifierOptionFuse <= `CCS_AMP_RESET;
         sleepMode <= `CCS_MODE_IDLE;
         asyncEnable <= 1'b0;
         converterEnable <= 1'b0;
         sleepRequest <= 1'b0;
      end else begin
         wbAckO <= busReq;
         sleepRequest <= 1'b0;
         wbDatO <= `CCS_ZERO32;
         if (busReq && !wbWeI) begin
            case (wbAdrI)
               `CCS_ADR_FUSE: wbDatO <= {25'h0, amplifierOptionFuse,
                  startupTimeFuses, clockSourceFuses};
               `CCS_ADR_CTRL: wbDatO <= {27'h0, converterEnable, asyncEnable,
                  sleepMode, 1'b0};
               `CCS_ADR_STAT: wbDatO <= {19'h0, state, crystalRange, sourceKind};
               `CCS_ADR_CNT: wbDatO <= {15'h0, count};
               default: wbDatO <= `CCS_ZERO32;
            endcase
         end
         if (busWrite && wbAdrI == `CCS_ADR_FUSE) begin
            clockSourceFuses <= wbDatI[`CCS_F_SRC_HI:`CCS_F_SRC_LO];
            startupTimeFuses <= wbDatI[`CCS_F_STARTUP_HI:`CCS_F_STARTUP_LO];
            amplifierOptionFuse <= wbDatI[`CCS_F_AMP];
         end
         if (busWrite && wbAdrI == `CCS_ADR_CTRL) begin
            sleepMode <= wbDatI[`CCS_C_MODE_HI:`CCS_C_MODE_LO];
            asyncEnable <= wbDatI[`CCS_C_ASY];
            converterEnable <= wbDatI[`CCS_C_ADC];
            sleepRequest <= wbDatI[`CCS_C_SLEEP];
         end
      end
   end

   // ----------------------------------------
   // start-up sequencer
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         state <= ST_LOAD;
         count <= `CCS_CNT_ZERO;
         wdogTarget <= `CCS_CNT_ZERO;
         fromReset <= 1'b1;
      end else begin
         case (state)
            ST_LOAD: begin
               // fuse decode settles one cycle after reset
               count <= next_oscTarget;
               wdogTarget <= next_wdTarget;
               state <= ST_OSC;
            end
            ST_RUN: begin
               if (sleepRequest) state <= ST_SLEEP;
            end
            ST_SLEEP: begin
               if (wakeRise && deepSleep) begin
                  count <= next_oscTarget;
                  fromReset <= 1'b0;
                  state <= ST_OSC;
               end else if (wakeRise) begin
                  state <= ST_RUN;
               end
            end
            ST_OSC: begin
               if (srcEdge && count <= `CCS_CNT_ONE) begin
                  if (fromReset && wdogTarget != `CCS_WD_NONE) begin
                     count <= wdogTarget;
                     state <= ST_WDOG;
                  end else begin
                     state <= ST_RUN;
                  end
               end else if (srcEdge) begin
                  count <= count - `CCS_CNT_ONE;
               end
            end
            ST_WDOG: begin
               if (wdEdge && count <= `CCS_CNT_ONE) begin
                  count <= `CCS_CNT_ZERO;
                  fromReset <= 1'b0;
                  state <= ST_RUN;
               end else if (wdEdge) begin
                  count <= count - `CCS_CNT_ONE;
               end
            end
            default: state <= ST_LOAD;
         endcase
      end
   end

   // ----------------------------------------
   // clock domain enables and decoded outputs
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         coreClockEn <= 1'b0;
         peripheralClockEn <= 1'b0;
         programMemoryClockEn <= 1'b0;
         asyncTimerClockEn <= 1'b0;
         converterClockEn <= 1'b0;
         asyncDetectEn <= 1'b1;
         amplifierFullSwing <= 1'b0;
         sourceKind <= 5'h00;
         crystalRange <= 3'h0;
         cpuHold <= 1'b1;
      end else begin
         sourceKind <= next_kind;
         amplifierFullSwing <= isCrystal && !amplifierOptionFuse;
         // range code from upper source bits, zero outside crystal mode
         crystalRange <= isCrystal ? clockSourceFuses[3:1] : 3'h0;
         cpuHold <= state != ST_RUN;
         // core halted in any sleep or start-up
         coreClockEn <= state == ST_RUN;
         programMemoryClockEn <= state == ST_RUN;
         // peripheral kept only in idle sleep
         peripheralClockEn <= (state == ST_RUN) ||
            (state == ST_SLEEP && sleepMode == `CCS_MODE_IDLE);
         asyncDetectEn <= 1'b1;
         // converter runs through noise reduction sleep
         converterClockEn <= converterEnable && ((state == ST_RUN) ||
            (state == ST_SLEEP && !deepSleep));
         // async timer only on internal oscillator
         asyncTimerClockEn <= asyncEnable && isInternal &&
            ((state == ST_RUN) || (state == ST_SLEEP && sleepMode != `CCS_MODE_PDOWN));
      end
   end

endmodule

// ### shared/ccs_regs.vh
`ifndef CCS_REGS_VH
`define CCS_REGS_VH
// Purpose: constants of the clock source select and start-up block
// Assumes: 32-bit classic Wishbone slave, byte addressing
// Notes: fuse bits read 1 when unprogrammed and 0 when programmed

// register byte offsets
`define CCS_ADR_FUSE 8'h00
`define CCS_ADR_CTRL 8'h04
`define CCS_ADR_STAT 8'h08
`define CCS_ADR_CNT 8'h0C

// fuse register fields
`define CCS_F_SRC_LO 0
`define CCS_F_SRC_HI 3
`define CCS_F_STARTUP_LO 4
`define CCS_F_STARTUP_HI 5
`define CCS_F_AMP 6
`define CCS_SRC_RESET 4'h1
`define CCS_STARTUP_RESET 2'h2
`define CCS_AMP_RESET 1'h1

// clock source codes
`define CCS_SRC_XTAL_MIN 4'hA
`define CCS_SRC_LFXTAL 4'h9
`define CCS_SRC_XRC_MIN 4'h5
`define CCS_SRC_IRC_MIN 4'h1
`define CCS_SRC_EXT 4'h0

// control register fields
`define CCS_C_SLEEP 0
`define CCS_C_MODE_LO 1
`define CCS_C_MODE_HI 2
`define CCS_C_ASY 3
`define CCS_C_ADC 4
`define CCS_MODE_IDLE 2'h0
`define CCS_MODE_ADCNR 2'h1
`define CCS_MODE_PDOWN 2'h2
`define CCS_MODE_PSAVE 2'h3

// crystal frequency range codes (upper three source bits)
`define CCS_RANGE_LOW 3'h5
`define CCS_RANGE_MID 3'h6
`define CCS_RANGE_HIGH 3'h7

// start-up counts in cycles of the selected source
`define CCS_CK_6 17'h00006
`define CCS_CK_258 17'h00102
`define CCS_CK_1K 17'h00400
`define CCS_CK_16K 17'h04000
// watchdog oscillator counts for the added reset delay
`define CCS_WD_NONE 17'h00000
`define CCS_WD_4K 17'h01000
`define CCS_WD_64K 17'h10000

`define CCS_CNT_ONE 17'h00001
`define CCS_CNT_ZERO 17'h00000
`define CCS_ZERO32 32'h00000000
`endif

// ### test/ccs_clock_control_monitor.sv
// Purpose: port checker for the clock control block
// Assumes: one clock, synchronous active-high reset
// Notes: attached to every instance by the bind at the foot
module ccs_clock_control_monitor (
   input wire clk,
   input wire rst,
   input wire wbCycI,
   input wire wbStbI,
   input wire [31:0] wbDatO,
   input wire wbAckO,
   input wire coreClockEn,
   input wire peripheralClockEn,
   input wire programMemoryClockEn,
   input wire asyncTimerClockEn,
   input wire converterClockEn,
   input wire asyncDetectEn,
   input wire amplifierFullSwing,
   input wire [4:0] sourceKind,
   input wire [2:0] crystalRange,
   input wire cpuHold
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_ACK_NEXT: assert property (wbCycI && wbStbI && !wbAckO |=> wbAckO)
      else $error("request not answered next cycle");
   AST_ACK_PULSE: assert property (wbAckO |=> !wbAckO) else $error("ack longer than a cycle");
   AST_DATA_IDLE: assert property (!wbAckO |-> wbDatO == 32'h0) else $error("read data off ack");
   AST_PMEM_CORE: assert property (programMemoryClockEn == coreClockEn)
      else $error("memory clock apart from core clock");
   AST_CORE_HOLD: assert property (coreClockEn != cpuHold)
      else $error("core clock and hold disagree");
   AST_DETECT: assert property (asyncDetectEn) else $error("async detect dropped");
   AST_PERIPH: assert property (coreClockEn |-> peripheralClockEn)
      else $error("peripheral clock off while running");
   AST_ASY_IRC: assert property (asyncTimerClockEn |-> sourceKind[3])
      else $error("async timer clock off internal oscillator");
   AST_KIND_ONEHOT: assert property (!$past(rst) |-> $onehot(sourceKind))
      else $error("source kind not one-hot");
   AST_RANGE_XTAL: assert property (!$past(rst) && !sourceKind[0] |-> crystalRange == 3'h0)
      else $error("range set outside crystal mode");
   AST_SWING_XTAL: assert property (amplifierFullSwing |-> sourceKind[0])
      else $error("full swing outside crystal mode");
   cover property ($fell(coreClockEn));
   cover property (converterClockEn && !coreClockEn);
   cover property (asyncTimerClockEn && !peripheralClockEn);
   cover property ($fell(cpuHold));
endmodule

bind ccs_clock_control ccs_clock_control_monitor u_mon (.clk(clk), .rst(rst),
   .wbCycI(wbCycI), .wbStbI(wbStbI), .wbDatO(wbDatO), .wbAckO(wbAckO),
   .coreClockEn(coreClockEn), .peripheralClockEn(peripheralClockEn),
   .programMemoryClockEn(programMemoryClockEn), .asyncTimerClockEn(asyncTimerClockEn),
   .converterClockEn(converterClockEn), .asyncDetectEn(asyncDetectEn),
   .amplifierFullSwing(amplifierFullSwing), .sourceKind(sourceKind),
   .crystalRange(crystalRange), .cpuHold(cpuHold));

// ### test/ccs_osc_model.sv
// Purpose: free-running oscillator in place of the external source
// Assumes: oscillators run free, so no idle level
// Notes: half period in ns, unrelated to the system clock
module ccs_osc_model #(
   parameter int HALF_NS = 155
) (
   output logic tick
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      tick = 1'b0;
      forever #(HALF_NS) tick = ~tick;
   end
endmodule

// ### test/tb_clock_source_select_startup.sv
// Purpose: self-checking bench for fuse decode, start-up timing, gating
// Assumes: counts shortened by parameters, 20 MHz clock
// Notes: hold times compared as ranges, oscillators are asynchronous
`include "ccs_regs.vh"
module tb_clock_source_select_startup;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SL = 16;
   localparam int WL = 32;
   localparam int SRC_NS = 310;
   localparam int WD_NS = 490;
   logic clk, rst, wbCycI, wbStbI, wbWeI, wakeEvent, wbAckO, sourceTick, watchdogTick;
   logic coreClockEn, peripheralClockEn, programMemoryClockEn, asyncTimerClockEn;
   logic converterClockEn, asyncDetectEn, amplifierFullSwing, cpuHold;
   logic [7:0] wbAdrI;
   logic [3:0] wbSelI, s;
   logic [31:0] wbDatI, wbDatO, rdData, seed, d;
   logic [4:0] sourceKind;
   logic [2:0] crystalRange;
   int num_errors, tests_run, n;

   ccs_osc_model #(.HALF_NS(SRC_NS / 2)) u_src (.tick(sourceTick));
   ccs_osc_model #(.HALF_NS(WD_NS / 2)) u_wd (.tick(watchdogTick));
   ccs_clock_control #(.STARTUP_LONG(17'h00010), .WATCHDOG_LONG(17'h00020)) u_dut (
      .clk(clk), .rst(rst), .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI),
      .wbSelI(wbSelI), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO),
      .sourceTick(sourceTick), .watchdogTick(watchdogTick), .wakeEvent(wakeEvent),
      .coreClockEn(coreClockEn), .peripheralClockEn(peripheralClockEn),
      .programMemoryClockEn(programMemoryClockEn), .asyncTimerClockEn(asyncTimerClockEn),
      .converterClockEn(converterClockEn), .asyncDetectEn(asyncDetectEn),
      .amplifierFullSwing(amplifierFullSwing), .sourceKind(sourceKind),
      .crystalRange(crystalRange), .cpuHold(cpuHold));

   // ---------------------------------------------
   // reference model
   // ---------------------------------------------
   function automatic logic [4:0] kind_of(input logic [3:0] c);
      return c >= 4'hA ? 5'h01 : c == 4'h9 ? 5'h02 : c >= 4'h5 ? 5'h04 : c >= 4'h1 ? 5'h08 : 5'h10;
   endfunction
   function automatic int start_n(input logic [3:0] c, input logic [1:0] stf);
      if (c < 4'hA) return 6;
      return {c[0], stf} < 3'h2 ? 258 : {c[0], stf} < 3'h5 ? 1024 : SL;
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // ---------------------------------------------
   // checks and bus
   // ---------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_range(input string what, input int lo, input int hi, input int got);
      tests_run++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
         input logic [31:0] dat);
      int k;
      k = 0;
      @(posedge clk);
      wbCycI <= 1'b1;
      wbStbI <= 1'b1;
      wbWeI <= we;
      wbAdrI <= adr;
      wbSelI <= sel;
      wbDatI <= dat;
      @(posedge clk);
      // no local limit: only the watchdog ends a hung wait
      while (wbAckO !== 1'b1) begin
         k++;
         @(posedge clk);
      end
      chk("bus ack delay", 1, k);
      rdData = wbDatO;
      wbCycI <= 1'b0;
      wbStbI <= 1'b0;
   endtask
   task automatic wait_run();
      n = 0;
      while (cpuHold !== 1'b0 && n < 20000) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic sleep_wake(input logic [1:0] m, input logic asy, input logic adc,
         input logic [3:0] c, input logic [1:0] stf);
      logic irc;
      irc = kind_of(c) == 5'h08;
      wb(1, `CCS_ADR_CTRL, 4'h1, {27'h0, adc, asy, m, 1'b1});
      repeat (6) @(posedge clk);
      chk("core en", 0, coreClockEn);
      chk("memory en", 0, programMemoryClockEn);
      chk("peripheral en", m == 2'h0, peripheralClockEn);
      chk("converter en", adc && m < 2'h2, converterClockEn);
      chk("async en", asy && irc && m != 2'h2, asyncTimerClockEn);
      chk("async detect", 1, asyncDetectEn);
      wb(0, `CCS_ADR_STAT, 4'h1, 32'h0);
      chk("sleep status", {19'h0, 5'h02, c >= 4'hA ? c[3:1] : 3'h0, kind_of(c)}, rdData);
      wakeEvent <= 1'b1;
      wait_run();
      wakeEvent <= 1'b0;
      if (m < 2'h2) chk_range("wake hold", 2, 12, n);
      else chk_range("wake hold", (start_n(c, stf) - 1) * SRC_NS / 50,
         (start_n(c, stf) * SRC_NS + 800) / 50, n);
      @(posedge clk);
      chk("run core en", 1, coreClockEn);
      chk("run converter en", adc, converterClockEn);
      chk("run async en", asy && irc, asyncTimerClockEn);
   endtask
   task automatic stop_test();
      if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // ---------------------------------------------
   // stimulus
   // ---------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #3000000;
      num_errors++;
      stop_test();
   end
   initial begin
      rst = 1'b1;
      {wbCycI, wbStbI, wbWeI, wakeEvent} = 4'h0;
      wbAdrI = 8'h00;
      wbSelI = 4'h0;
      wbDatI = 32'h0;
      seed = 32'h99CB1901;
      num_errors = 0;
      tests_run = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      wait_run();
      chk_range("reset hold", (5 * SRC_NS + (WL - 1) * WD_NS) / 50,
         (6 * SRC_NS + WL * WD_NS + 1000) / 50, n);
      wb(0, `CCS_ADR_FUSE, 4'h1, 32'h0);
      chk("delivered fuses", 32'h00000061, rdData);
      wb(1, `CCS_ADR_FUSE, 4'hE, 32'hFFFFFF00);
      wb(0, `CCS_ADR_FUSE, 4'h1, 32'h0);
      chk("masked fuse write", 32'h00000061, rdData);
      wb(0, 8'h10, 4'h1, 32'h0);
      chk("unmapped read", 0, rdData);
      for (int f = 0; f < 32; f++) begin
         seed = xs(seed);
         d = {seed[31:7], f[4], seed[5:4], f[3:0]};
         wb(1, `CCS_ADR_FUSE, 4'h1, d);
         wb(0, `CCS_ADR_FUSE, 4'h1, 32'h0);
         chk("fuse readback", {25'h0, d[6:0]}, rdData);
         chk("source kind", kind_of(d[3:0]), sourceKind);
         chk("crystal range", d[3:0] >= 4'hA ? d[3:1] : 3'h0, crystalRange);
         chk("full swing", d[3:0] >= 4'hA && !d[6], amplifierFullSwing);
      end
      for (int m = 0; m < 4; m++) begin
         seed = xs(seed);
         s = {2'b00, seed[1:0]} + 4'h1;
         wb(1, `CCS_ADR_FUSE, 4'h1, {25'h0, 1'b1, seed[3:2], s});
         sleep_wake(m[1:0], seed[4], seed[5], s, seed[3:2]);
      end
      wb(1, `CCS_ADR_CTRL, 4'h1, 32'h0);
      for (int c = 0; c < 8; c++) begin
         wb(1, `CCS_ADR_FUSE, 4'h1, {25'h0, 1'b1, c[1:0], 3'b101, c[2]});
         sleep_wake({1'b1, c[0]}, 1'b1, c[1], {3'b101, c[2]}, c[1:0]);
      end
      stop_test();
   end
endmodule
